// ### verilog/process_data_consts.vh
// What this block does
// - hold request stops measure pulses at once and freezes the actual value
// - during hold only supply class errors are evaluated and reported
// - hold release resumes at once, no init; hold never clears alarms
// - hold only in measurement mode; heat, clear, calibration take priority
// - hold ignored after power-up until the system check passed
// - three-bit field selects one of eight calibration sets, except during a running calibration
// - calibration keeps its starting channel; channel in use is reported
// - channel is not retained; after restart channel 0 is used
// - setpoint limited to 300 or 500 C; reject or clamp by variant
// - primary heat input heats to setpoint 0, secondary to setpoint 1
// - no heating when setpoint not above 40 C; heat indicator blinks
// - heat request during pending warning energises alarm output, no heat
// - primary input beats bus heat; secondary input has lowest priority
// - calibration running flag follows calibration busy, one clock cycle later
// - calibration locked flag while heat request active or cooling down
// - fault flag set on alarm and held until a clear request, with error number
// - caution flag alongside fault flag for warnings; relay stays off
// - near target flag at 95 percent; cleared on heat drop or alarm
// - in-band mode off reads 0; default follows tolerance band
// - latch mode sets on first band entry per cycle, clears on exit while heat is on
// - separate lower and upper band limits, each up to 99 K
// - regulating flag when heat accepted; spare info flag always 0
// - standby flag while clear request set or hold accepted, as handshake
// - no heating during calibration, alarm, low setpoint or clear
`ifndef PROCESS_DATA_CONSTS_VH
`define PROCESS_DATA_CONSTS_VH

`define TEMP_W          10
`define LIMIT_LOW_RANGE 10'h12C
`define LIMIT_HIGH_RANGE 10'h1F4
`define MIN_HEAT_TEMP   10'h028
`define BAND_MAX        7'h63
`define CHAN_DEFAULT    3'h0
`define BLINK_HALF_CNT  24'h989680
`define BAND_OFF        2'h0
`define BAND_FOLLOW     2'h1
`define BAND_LATCH      2'h2
`define SRC_NONE        2'h0
`define SRC_BUS         2'h1
`define SRC_PRIMARY     2'h2
`define SRC_SECONDARY   2'h3
`define ERR_KEEP_LO     10'h0C9
`define ERR_KEEP_HI     10'h0CB
`define ERR_KEEP_A      10'h385
`define ERR_KEEP_B      10'h391

`endif

// ### verilog/process_data_control_status.v
`timescale 1ns/1ps
`include "process_data_consts.vh"

module process_data_control_status #(
  parameter TW             = `TEMP_W,
  parameter BLINK_HALF     = `BLINK_HALF_CNT
) (
  input  wire          clk,
  input  wire          rst_n,
  // requests from the bus master
  input  wire          heat_request,
  input  wire          clear_request,
  input  wire          measure_hold_request,
  input  wire          calib_request,
  input  wire [2:0]    calib_set_select,
  input  wire [TW-1:0] setpoint0_wr,
  input  wire [TW-1:0] setpoint1_wr,
  input  wire          setpoint_wr_en,
  input  wire          clamp_variant,
  input  wire          high_range,
  input  wire [1:0]    band_mode,
  input  wire [6:0]    band_lower,
  input  wire [6:0]    band_upper,
  // hardwired heat inputs
  input  wire          heat_in_primary,
  input  wire          heat_in_secondary,
  // device side status
  input  wire          system_check_done,
  input  wire          measure_mode,
  input  wire          calib_busy,
  input  wire          cooling_down,
  input  wire          alarm_event,
  input  wire          alarm_is_warning,
  input  wire [9:0]    alarm_number,
  input  wire          warning_pending,
  input  wire [TW-1:0] measured_temp,
  input  wire          measure_valid,
  // outputs
  output reg           measure_pulse_enable,
  output reg  [TW-1:0] actual_temp,
  output reg  [9:0]    error_number,
  output reg  [2:0]    calib_set_in_use,
  output reg  [TW-1:0] setpoint0,
  output reg  [TW-1:0] setpoint1,
  output reg           setpoint_rejected,
  output reg           heating_enable,
  output reg           use_setpoint1,
  output reg           heat_indicator,
  output reg           alarm_relay,
  output reg           calib_running_flag,
  output reg           calib_locked_status,
  output reg           fault_latched_status,
  output reg           caution_only_status,
  output reg           near_target_status,
  output reg           in_band_status,
  output reg           regulating_status,
  output reg           spare_info_status,
  output reg           idle_standby_status
);

  // ==========================================================
  // request arbitration
  // ==========================================================
  reg  [1:0]    src_d;
  reg           any_heat;
  wire          use_sp1;
  wire [TW-1:0] sp_active;
  wire          sp_ok;
  wire          heat_blocked;
  wire          hold_active;
  wire [9:0]    err_filtered;
  wire          err_allowed;
  reg  [TW-1:0] sp_limit;

  // any source counts, even a refused one, so it still beats a hold
  // primary pin wins, then bus, secondary pin last
  always @*
  begin
    src_d = `SRC_NONE;
    if (heat_in_primary)
      src_d = `SRC_PRIMARY;
    else if (heat_request)
      src_d = `SRC_BUS;
    else if (heat_in_secondary)
      src_d = `SRC_SECONDARY;
    any_heat = (src_d != `SRC_NONE);
  end

  // bus heat uses setpoint 0; only the secondary pin picks setpoint 1
  // the band and 95 percent tests judge against this active setpoint
  assign use_sp1   = (src_d == `SRC_SECONDARY);
  assign sp_active = use_sp1 ? setpoint1 : setpoint0;
  assign sp_ok     = (sp_active > `MIN_HEAT_TEMP);

  // any of these keeps the heater off even with a request standing;
  // calib_busy itself, not its registered copy, so the very first
  // calibration cycle already keeps the heater off
  assign heat_blocked = calib_busy | fault_latched_status |
                        ~sp_ok | clear_request | warning_pending;

  // hold loses to heat, clear and calibration
  assign hold_active = measure_hold_request & system_check_done &
                       measure_mode & ~any_heat & ~clear_request &
                       ~calib_busy & ~calib_request;

  // only the supply class errors survive a hold or a clear
  assign err_allowed = ((alarm_number >= `ERR_KEEP_LO) &&
                        (alarm_number <= `ERR_KEEP_HI)) ||
                       (alarm_number == `ERR_KEEP_A) ||
                       (alarm_number == `ERR_KEEP_B);
  assign err_filtered = alarm_number;

  // the range input picks the ceiling used by both setpoint writes
  always @*
  begin
    sp_limit = high_range ? `LIMIT_HIGH_RANGE : `LIMIT_LOW_RANGE;
  end

  // ==========================================================
  // blink divider for the refused heat indicator
  // ==========================================================
  reg [23:0] blink_cnt_q;
  reg        blink_q;

  // half period of the blink; a fixed tick keeps every refusal in phase
  // a BLINK_HALF of 0 wraps to the slowest blink, so keep it at 1 or more
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      blink_cnt_q <= 24'h000000;
      blink_q     <= 1'b0;
    end
    else if (blink_cnt_q >= BLINK_HALF - 24'h000001)
    begin
      blink_cnt_q <= 24'h000000;
      blink_q     <= ~blink_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 24'h000001;
  end

  // ==========================================================
  // setpoints, channel and measurement hold
  // ==========================================================
  reg  calib_busy_q;
  reg  heat_prev_q;
  reg  cycle_seen_q;
  wire sp0_big;
  wire sp1_big;
  wire [TW-1:0] temp_x20;
  wire [TW+4:0] act_x20;
  wire [TW+4:0] sp_x19;
  wire          in_band;
  wire [TW:0]   band_lo;
  wire [TW:0]   band_hi;
  wire [6:0]    lo_lim;
  wire [6:0]    hi_lim;

  assign sp0_big = (setpoint0_wr > sp_limit);
  assign sp1_big = (setpoint1_wr > sp_limit);

  // writes over the range: clamp in one variant, refuse in the other
  // a refused write leaves both setpoints as they were
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      setpoint0         <= {TW{1'b0}};
      setpoint1         <= {TW{1'b0}};
      setpoint_rejected <= 1'b0;
    end
    else if (setpoint_wr_en)
    begin
      if (clamp_variant)
      begin
        setpoint0         <= sp0_big ? sp_limit : setpoint0_wr;
        setpoint1         <= sp1_big ? sp_limit : setpoint1_wr;
        setpoint_rejected <= 1'b0;
      end
      else if (sp0_big | sp1_big)
        setpoint_rejected <= 1'b1;
      else
      begin
        setpoint0         <= setpoint0_wr;
        setpoint1         <= setpoint1_wr;
        setpoint_rejected <= 1'b0;
      end
    end
  end

  // channel follows the field except while a calibration is running
  // a change in the first calibration cycle is still taken
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      calib_set_in_use <= `CHAN_DEFAULT;
      calib_busy_q     <= 1'b0;
    end
    else
    begin
      calib_busy_q <= calib_busy;
      if (!calib_busy || !calib_busy_q)
        calib_set_in_use <= calib_set_select;
    end
  end

  // freeze the actual value while holding; release resumes at once
  // a filtered error reads as 0, so the master never sees a stale
  // cause that the hold or the clear is hiding
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      measure_pulse_enable <= 1'b0;
      actual_temp          <= {TW{1'b0}};
      error_number         <= 10'h000;
    end
    else
    begin
      measure_pulse_enable <= ~hold_active;
      if (!hold_active && measure_valid)
        actual_temp <= measured_temp;
      if (!(hold_active || clear_request) || err_allowed)
        error_number <= err_filtered;
      else
        error_number <= 10'h000;
    end
  end

  // ==========================================================
  // temperature comparisons
  // ==========================================================
  // 95 percent test without a divider: 20*act >= 19*sp; five extra
  // bits keep twenty times the largest reading from overflowing
  assign act_x20 = {1'b0, actual_temp, 4'h0} + {3'b000, actual_temp, 2'b00};
  assign sp_x19  = {1'b0, sp_active, 4'h0} + {4'h0, sp_active, 1'b0} +
                   {5'h00, sp_active};
  assign temp_x20 = actual_temp;

  // band limits saturate at 99 K; band_lo may dip below zero for a
  // small setpoint, and the signed compare then sees no lower limit
  assign lo_lim  = (band_lower > `BAND_MAX) ? `BAND_MAX : band_lower;
  assign hi_lim  = (band_upper > `BAND_MAX) ? `BAND_MAX : band_upper;
  assign band_lo = {1'b0, sp_active} - {{(TW-6){1'b0}}, lo_lim};
  assign band_hi = {1'b0, sp_active} + {{(TW-6){1'b0}}, hi_lim};
  assign in_band = ($signed(band_lo) <= $signed({1'b0, temp_x20})) &&
                   ({1'b0, temp_x20} <= band_hi);

  // ==========================================================
  // status flags, refreshed every cycle
  // ==========================================================
  // all flags update on the same clock edge; relay and heat enable follow the fault flag one cycle later
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      heating_enable       <= 1'b0;
      use_setpoint1        <= 1'b0;
      heat_indicator       <= 1'b0;
      alarm_relay          <= 1'b0;
      calib_running_flag   <= 1'b0;
      calib_locked_status  <= 1'b0;
      fault_latched_status <= 1'b0;
      caution_only_status  <= 1'b0;
      near_target_status   <= 1'b0;
      in_band_status       <= 1'b0;
      regulating_status    <= 1'b0;
      spare_info_status    <= 1'b0;
      idle_standby_status  <= 1'b0;
      heat_prev_q          <= 1'b0;
      cycle_seen_q         <= 1'b0;
    end
    else
    begin
      heat_prev_q        <= any_heat;
      calib_running_flag <= calib_busy;
      calib_locked_status <= any_heat | cooling_down;
      spare_info_status  <= 1'b0;
      // only an accepted hold is acknowledged; a refused one gives no
      // standby, so the master keeps its request up until it is taken
      idle_standby_status <= clear_request | hold_active;
      use_setpoint1      <= use_sp1;

      // alarm stays until a clear; a new event wins over the clear
      if (alarm_event)
      begin
        fault_latched_status <= 1'b1;
        caution_only_status  <= alarm_is_warning;
      end
      else if (clear_request)
      begin
        fault_latched_status <= 1'b0;
        caution_only_status  <= 1'b0;
      end

      // relay for hard alarms, or a heat attempt over a warning
      // a warning alone never pulls the relay in
      alarm_relay <= (fault_latched_status & ~caution_only_status) |
                     (any_heat & warning_pending);

      // one term drives both, so a refused request never reads as
      // regulating, at the cost of no separate accept register
      heating_enable    <= any_heat & ~heat_blocked;
      regulating_status <= any_heat & ~heat_blocked;
      heat_indicator    <= any_heat &
                           (heat_blocked ? blink_q : 1'b1);

      // near target drops with the request or an alarm
      if (!any_heat || fault_latched_status || alarm_event)
        near_target_status <= 1'b0;
      else if (act_x20 >= sp_x19)
        near_target_status <= 1'b1;

      case (band_mode)
        `BAND_OFF:
          in_band_status <= 1'b0;
        `BAND_FOLLOW:
          in_band_status <= in_band;
        // with no heat source the latched flag is left as it is
        `BAND_LATCH:
        begin
          if (any_heat && !heat_prev_q)
          begin
            cycle_seen_q   <= in_band;
            in_band_status <= in_band;
          end
          else if (any_heat && !in_band)
            in_band_status <= 1'b0;
          else if (any_heat && in_band && !cycle_seen_q)
          begin
            cycle_seen_q   <= 1'b1;
            in_band_status <= 1'b1;
          end
        end
        default:
          in_band_status <= 1'b0;
      endcase
    end
  end

endmodule // process_data_control_status

// ### verification/process_data_control_status_assertions.sv
`timescale 1ns/1ps
module process_data_control_status_checker #(
  parameter TW = 10
) (
  input wire          clk,
  input wire          rst_n,
  input wire          heat_request,
  input wire          clear_request,
  input wire          measure_hold_request,
  input wire          calib_request,
  input wire [2:0]    calib_set_select,
  input wire          heat_in_primary,
  input wire          heat_in_secondary,
  input wire          system_check_done,
  input wire          measure_mode,
  input wire          calib_busy,
  input wire          cooling_down,
  input wire          alarm_event,
  input wire          alarm_is_warning,
  input wire          warning_pending,
  input wire          measure_pulse_enable,
  input wire [TW-1:0] actual_temp,
  input wire [2:0]    calib_set_in_use,
  input wire          heating_enable,
  input wire          use_setpoint1,
  input wire          calib_running_flag,
  input wire          calib_locked_status,
  input wire          fault_latched_status,
  input wire          caution_only_status,
  input wire          spare_info_status,
  input wire          idle_standby_status
);
  // ==========================================
  // helpers
  // up_q keeps $past away from values seen during reset
  reg  up_q;
  wire hold_ok;
  always @(posedge clk)
  begin
    up_q <= rst_n;
  end
  // hold is only honoured with no competing request
  assign hold_ok = up_q && measure_hold_request && system_check_done &&
    measure_mode && !heat_request && !heat_in_primary &&
    !heat_in_secondary && !clear_request && !calib_busy && !calib_request;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // assertions
  hold_stops_a: assert property (hold_ok |=>
    !measure_pulse_enable && idle_standby_status) else $error("hold ignored");
  hold_freeze_a: assert property (hold_ok ##1 hold_ok |=>
    $stable(actual_temp)) else $error("actual value moved in hold");
  hold_gated_a: assert property (up_q && measure_hold_request &&
    !system_check_done && !clear_request |=> !idle_standby_status)
    else $error("hold taken before system check");
  clear_ack_a: assert property (up_q && clear_request |=>
    idle_standby_status) else $error("no standby on clear");
  hold_keeps_alarm_a: assert property (hold_ok && fault_latched_status
    |=> fault_latched_status) else $error("hold cleared alarm");
  caution_flag_a: assert property (up_q && alarm_event &&
    alarm_is_warning && !clear_request && !measure_hold_request |=>
    fault_latched_status && caution_only_status) else $error("no warning");
  chan_follow_a: assert property (up_q && !calib_busy |=>
    calib_set_in_use == $past(calib_set_select)) else $error("channel");
  chan_kept_a: assert property (up_q && calib_busy ##1 calib_busy |=>
    $stable(calib_set_in_use)) else $error("channel moved in calibration");
  calib_run_a: assert property (up_q |=>
    calib_running_flag == $past(calib_busy)) else $error("running flag");
  calib_lock_a: assert property (up_q && (heat_request || cooling_down)
    |=> calib_locked_status) else $error("calibration not locked");
  heat_block_a: assert property (up_q && (calib_busy || clear_request ||
    warning_pending) |=> !heating_enable) else $error("heat not blocked");
  heat_prio_a: assert property (up_q && heat_in_primary |=>
    !use_setpoint1) else $error("secondary beat primary");
  spare_zero_a: assert property (spare_info_status == 1'b0)
    else $error("spare flag set");
  // main scenarios reached
  cover property (hold_ok ##1 hold_ok);
  cover property (calib_busy ##1 calib_busy);
  cover property (alarm_event && alarm_is_warning);
  cover property (heat_in_primary && heat_in_secondary);
endmodule // process_data_control_status_checker

bind process_data_control_status process_data_control_status_checker
  #(.TW(TW)) chk_i (.clk(clk), .rst_n(rst_n), .heat_request(heat_request),
  .clear_request(clear_request), .measure_hold_request(measure_hold_request),
  .calib_request(calib_request), .calib_set_select(calib_set_select),
  .heat_in_primary(heat_in_primary), .heat_in_secondary(heat_in_secondary),
  .system_check_done(system_check_done), .measure_mode(measure_mode),
  .calib_busy(calib_busy), .cooling_down(cooling_down),
  .alarm_event(alarm_event), .alarm_is_warning(alarm_is_warning),
  .warning_pending(warning_pending),
  .measure_pulse_enable(measure_pulse_enable), .actual_temp(actual_temp),
  .calib_set_in_use(calib_set_in_use), .heating_enable(heating_enable),
  .use_setpoint1(use_setpoint1), .calib_running_flag(calib_running_flag),
  .calib_locked_status(calib_locked_status),
  .fault_latched_status(fault_latched_status),
  .caution_only_status(caution_only_status),
  .spare_info_status(spare_info_status),
  .idle_standby_status(idle_standby_status));

// ### verification/plc_master_model.sv
`timescale 1ns/1ps
module plc_master_model (
  input  wire clk,
  input  wire rst_n,
  input  wire want_hold,
  input  wire want_clear,
  input  wire idle_standby_status,
  output wire measure_hold_request,
  output wire clear_request
);
  reg hold_q;
  reg clear_q;
  // a request is withdrawn only once standby has been seen
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      hold_q  <= 1'b0;
      clear_q <= 1'b0;
    end
    else
    begin
      hold_q  <= want_hold | (hold_q & ~idle_standby_status);
      clear_q <= want_clear | (clear_q & ~idle_standby_status);
    end
  end
  assign measure_hold_request = hold_q;
  assign clear_request        = clear_q;
endmodule // plc_master_model

// ### verification/process_data_control_status_tb.sv
`timescale 1ns/1ps
module process_data_control_status_tb;
  reg clk = 0, rst_n = 0, heat_request = 0, want_hold = 0, want_clear = 0;
  reg calib_request = 0, setpoint_wr_en = 0, clamp_variant = 1;
  reg high_range = 0, heat_in_primary = 0, heat_in_secondary = 0;
  reg system_check_done = 0, measure_mode = 1, calib_busy = 0;
  reg cooling_down = 0, alarm_event = 0, alarm_is_warning = 0;
  reg warning_pending = 0, measure_valid = 1;
  reg [2:0] calib_set_select = 3'h0;
  reg [1:0] band_mode = 2'h1;
  reg [6:0] band_lower = 7'h05, band_upper = 7'h05;
  reg [9:0] sp0_w = 10'h000, sp1_w = 10'h000, alarm_number = 10'h000;
  reg [9:0] measured_temp = 10'h000;
  reg [1:0] seen;
  wire clear_request, measure_hold_request, pulse_en, sp_rej, heat_en;
  wire use_sp1, relay, running, locked, fault, caution, near, in_band;
  wire regulating, spare, standby, hind;
  wire [9:0] actual_temp, setpoint0, setpoint1, err_no;
  wire [2:0] chan;
  integer miscompares = 0, checks_done = 0, cycles = 0, i;
  always #12.5 clk = ~clk;
  plc_master_model plc_master_model_i (.clk(clk), .rst_n(rst_n),
    .want_hold(want_hold), .want_clear(want_clear),
    .idle_standby_status(standby), .measure_hold_request(measure_hold_request),
    .clear_request(clear_request));
  process_data_control_status #(.BLINK_HALF(24'h000004))
    process_data_control_status_i (.clk(clk), .rst_n(rst_n),
    .heat_request(heat_request), .clear_request(clear_request),
    .measure_hold_request(measure_hold_request), .calib_request(calib_request),
    .calib_set_select(calib_set_select), .setpoint0_wr(sp0_w),
    .setpoint1_wr(sp1_w), .setpoint_wr_en(setpoint_wr_en),
    .clamp_variant(clamp_variant), .high_range(high_range),
    .band_mode(band_mode), .band_lower(band_lower), .band_upper(band_upper),
    .heat_in_primary(heat_in_primary), .heat_in_secondary(heat_in_secondary),
    .system_check_done(system_check_done), .measure_mode(measure_mode),
    .calib_busy(calib_busy), .cooling_down(cooling_down),
    .alarm_event(alarm_event), .alarm_is_warning(alarm_is_warning),
    .alarm_number(alarm_number), .warning_pending(warning_pending),
    .measured_temp(measured_temp), .measure_valid(measure_valid),
    .measure_pulse_enable(pulse_en), .actual_temp(actual_temp),
    .error_number(err_no), .calib_set_in_use(chan), .setpoint0(setpoint0),
    .setpoint1(setpoint1), .setpoint_rejected(sp_rej),
    .heating_enable(heat_en),
    .use_setpoint1(use_sp1), .heat_indicator(hind), .alarm_relay(relay),
    .calib_running_flag(running), .calib_locked_status(locked),
    .fault_latched_status(fault), .caution_only_status(caution),
    .near_target_status(near), .in_band_status(in_band),
    .regulating_status(regulating), .spare_info_status(spare),
    .idle_standby_status(standby));
  // ==========================================
  // shared tasks
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one write pulse loads both setpoints
  task wr_sp(input logic [9:0] a, input logic [9:0] b);
    @(posedge clk);
    sp0_w <= a;
    sp1_w <= b;
    setpoint_wr_en <= 1'b1;
    @(posedge clk);
    setpoint_wr_en <= 1'b0;
    step(2);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, the sequence needs well under 1000 cycles
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    step(2);
    chk(chan, 3'h0);
    chk(spare, 1'b0);
    for (i = 0; i < 8; i = i + 1)
    begin
      @(posedge clk);
      calib_set_select <= i[2:0];
      step(2);
      chk(chan, i[2:0]);
    end
    @(posedge clk);
    calib_set_select <= 3'h3;
    calib_busy <= 1'b1;
    @(posedge clk);
    calib_set_select <= 3'h5;
    step(3);
    chk(chan, 3'h3);
    chk(running, 1'b1);
    @(posedge clk);
    calib_busy <= 1'b0;
    step(2);
    chk(chan, 3'h5);
    chk(running, 1'b0);
    // hold before the system check must be ignored
    @(posedge clk);
    measured_temp <= 10'h064;
    want_hold <= 1'b1;
    step(4);
    chk(actual_temp, 10'h064);
    chk(standby, 1'b0);
    chk(pulse_en, 1'b1);
    @(posedge clk);
    system_check_done <= 1'b1;
    step(3);
    @(posedge clk);
    measured_temp <= 10'h0C8;
    step(3);
    chk(pulse_en, 1'b0);
    chk(standby, 1'b1);
    chk(actual_temp, 10'h064);
    @(posedge clk);
    want_hold <= 1'b0;
    step(5);
    chk(pulse_en, 1'b1);
    chk(actual_temp, 10'h0C8);
    // calibration request outranks hold
    @(posedge clk);
    calib_request <= 1'b1;
    want_hold <= 1'b1;
    step(3);
    chk(standby, 1'b0);
    @(posedge clk);
    calib_request <= 1'b0;
    want_hold <= 1'b0;
    step(5);
    // hardwired heat inputs and their priority
    wr_sp(10'h064, 10'h0C8);
    @(posedge clk);
    heat_in_secondary <= 1'b1;
    step(2);
    chk(heat_en, 1'b1);
    chk(use_sp1, 1'b1);
    @(posedge clk);
    heat_in_primary <= 1'b1;
    step(3);
    chk(use_sp1, 1'b0);
    chk(regulating, 1'b1);
    chk(near, 1'b1);
    @(posedge clk);
    heat_in_primary <= 1'b0;
    heat_in_secondary <= 1'b0;
    step(3);
    chk(heat_en, 1'b0);
    chk(near, 1'b0);
    wr_sp(10'h028, 10'h028);
    @(posedge clk);
    heat_in_primary <= 1'b1;
    step(3);
    chk(heat_en, 1'b0);
    seen = 2'b00;
    repeat (8)
    begin
      step(1);
      seen = seen | (hind ? 2'b10 : 2'b01);
    end
    chk(seen, 2'b11);
    @(posedge clk);
    heat_in_primary <= 1'b0;
    // setpoint limits: clamp low range, clamp high range, reject
    wr_sp(10'h258, 10'h064);
    chk(setpoint0, 10'h12C);
    chk(setpoint1, 10'h064);
    high_range <= 1'b1;
    wr_sp(10'h258, 10'h064);
    chk(setpoint0, 10'h1F4);
    clamp_variant <= 1'b0;
    wr_sp(10'h258, 10'h0C8);
    chk(sp_rej, 1'b1);
    chk(setpoint1, 10'h064);
    chk(setpoint0, 10'h1F4);
    wr_sp(10'h064, 10'h064);
    // heat over a pending warning trips the relay
    @(posedge clk);
    warning_pending <= 1'b1;
    heat_request <= 1'b1;
    cooling_down <= 1'b1;
    step(2);
    chk(heat_en, 1'b0);
    chk(relay, 1'b1);
    chk(locked, 1'b1);
    @(posedge clk);
    warning_pending <= 1'b0;
    heat_request <= 1'b0;
    cooling_down <= 1'b0;
    @(posedge clk);
    alarm_event <= 1'b1;
    alarm_is_warning <= 1'b1;
    alarm_number <= 10'h068;
    @(posedge clk);
    alarm_event <= 1'b0;
    step(2);
    chk(fault, 1'b1);
    chk(caution, 1'b1);
    chk(relay, 1'b0);
    chk(err_no, 10'h068);
    @(posedge clk);
    want_hold <= 1'b1;
    step(3);
    chk(fault, 1'b1);
    chk(err_no, 10'h000);
    @(posedge clk);
    want_hold <= 1'b0;
    want_clear <= 1'b1;
    alarm_number <= 10'h385;
    step(4);
    chk(standby, 1'b1);
    chk(err_no, 10'h385);
    @(posedge clk);
    want_clear <= 1'b0;
    measured_temp <= 10'h060;
    step(5);
    chk(fault, 1'b0);
    // tolerance band: follow, saturated upper limit, latch, then off
    chk(in_band, 1'b1);
    @(posedge clk);
    band_upper <= 7'h7F;
    measured_temp <= 10'h0DC;
    step(3);
    chk(in_band, 1'b0);
    @(posedge clk);
    band_mode <= 2'h2;
    band_upper <= 7'h05;
    measured_temp <= 10'h05A;
    heat_request <= 1'b1;
    step(3);
    chk(in_band, 1'b0);
    @(posedge clk);
    measured_temp <= 10'h064;
    step(3);
    chk(in_band, 1'b1);
    chk(near, 1'b1);
    @(posedge clk);
    heat_request <= 1'b0;
    measured_temp <= 10'h05A;
    step(3);
    chk(in_band, 1'b1);
    @(posedge clk);
    band_mode <= 2'h0;
    step(2);
    chk(in_band, 1'b0);
    give_verdict;
  end
endmodule // process_data_control_status_tb
